// File: core/color_pipe_pkg.sv
/*
  Shared definitions for the colour pipe back end and output formatter:
  register map, field positions, reset values, stage coefficients, carriers.
  Assumes one 32-bit AHB-Lite word per register and a 100 MHz core clock.
*/
package color_pipe_pkg;
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_SHARP = 12'h004;
  localparam logic [11:0] REG_BLEND = 12'h008;
  localparam logic [11:0] REG_KILL = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_CCM_BASE = 12'h020;
  localparam logic [11:0] REG_GAM_BRIGHT = 12'h080;
  localparam logic [11:0] REG_GAM_DARK = 12'h100;
  // control fields
  localparam int CTRL_W = 11;
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_CCM_AUTO = 3;
  localparam int CTRL_SWAP_CBCR = 4;
  localparam int CTRL_SWAP_YC = 5;
  localparam int CTRL_Y_LPF_EN = 6;
  localparam int CTRL_Y_LPF5 = 7;
  localparam int CTRL_UV_LPF_EN = 8;
  localparam int CTRL_UV_LPF5 = 9;
  localparam int CTRL_CROP = 10;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [15:0] SHARP_RESET = 16'h1002;
  localparam logic [7:0] BLEND_RESET = 8'h00;
  localparam logic [15:0] KILL_RESET = 16'h00ff;
  // colour correction
  localparam int CCM_N = 9;
  localparam int CCM_W = 10;
  localparam int CCM_SHIFT = 8;
  localparam logic [9:0] CCM_UNITY = 10'h100;
  localparam int MAX12 = 4095;
  localparam int MAX8 = 255;
  localparam int SHARP_SHIFT = 3;
  localparam int SHARP_THR_SHIFT = 4;
  // gamma knees
  localparam int GAMMA_KNEES = 19;
  localparam int KNEE_1 = 64;
  localparam int KNEE_2 = 128;
  localparam int KNEE_STEP_SHIFT = 8;
  localparam int KNEE_FINE_SHIFT = 6;
  localparam int KNEE_MID_SHIFT = 7;
  localparam int KNEE_COARSE_BASE = 2;
  typedef logic [18:0][7:0] gamma_tbl_t;
  localparam gamma_tbl_t GAMMA_BRIGHT_RESET = {8'hff, 8'hf0, 8'he0, 8'hd0, 8'hc0, 8'hb0,
    8'ha0, 8'h90, 8'h80, 8'h70, 8'h60, 8'h50, 8'h40, 8'h30, 8'h20, 8'h10, 8'h08, 8'h04, 8'h00};
  localparam gamma_tbl_t GAMMA_DARK_RESET = {8'hff, 8'hfa, 8'hf4, 8'hee, 8'he7, 8'hdf,
    8'hd7, 8'hce, 8'hc4, 8'hb9, 8'had, 8'h9f, 8'h90, 8'h7e, 8'h69, 8'h50, 8'h38, 8'h28, 8'h00};
  localparam int BLEND_ONE = 256;
  localparam int FRAC8 = 8;
  localparam int CHROMA_MID = 128;
  // yuv matrices, scaled by 256
  localparam int KY_R = 77, KY_G = 150, KY_B = 29;
  localparam int KU_R = -43, KU_G = -85, KU_B = 128;
  localparam int KV_R = 128, KV_G = -107, KV_B = -21;
  localparam int KR_V = 359, KG_U = -88, KG_V = -183, KB_U = 454;
  // preview window and bt.656 codes
  localparam int PREVIEW_COLS = 640;
  localparam int PREVIEW_ROWS = 480;
  localparam logic [7:0] SYNC_FF = 8'hff;
  localparam logic [7:0] SYNC_00 = 8'h00;
  localparam int CODE_LEN = 4;

  typedef enum logic [2:0] {
    FMT_YCBCR, FMT_BT656, FMT_RGB565, FMT_RGB555,
    FMT_RGB444X, FMT_RGBX444, FMT_RAW_GPIO, FMT_RAW_2BYTE
  } out_fmt_t;
  typedef struct packed {logic frame_active; logic row_active;} qual_t;
  typedef struct packed {logic [11:0] r; logic [11:0] g; logic [11:0] b;} rgb12_t;
  typedef struct packed {logic [7:0] y; logic [7:0] u; logic [7:0] v;} yuv_t;
  typedef struct packed {logic clk; qual_t q; logic [29:0] rgb; logic [9:0] raw;} link_pins_t;
  typedef struct packed {logic [7:0] data; logic [1:0] lsb; qual_t q;} out_byte_t;
endpackage

// File: core/color_pipe_out.sv
/*
  Colour pipe back end and parallel output formatter with AHB-Lite registers.
  Assumes link pins (clock, qualifiers, rgb, raw) come from another clock
  domain and change on the falling edge of the link clock; the core clock
  runs at least four times faster than the link clock.
*/
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
// Operation
// RQ1 - 3x3 matrix, widen to 12-bit colours
// RQ2 - matrix from registers or auto balance
// RQ3 - sharpening after correction, programmable gain, threshold
// RQ4 - bright and dark tables blended, reset defaults
// RQ5 - 19-knee piecewise gamma, 12 to 8 bits
// RQ6 - fixed knee inputs, programmable outputs only
// RQ7 - convert rgb to yuv after gamma
// RQ8 - colour kill attenuates chroma above threshold
// RQ9 - optional 3/5-tap low-pass, Y and UV
// RQ10 - output yuv as-is or convert to rgb
// RQ11 - YCbCr order by two swap controls
// RQ12 - rgb swaps: byte order, red/blue exchange
// RQ13 - 565 and 555 byte layouts
// RQ14 - 444x and x444 byte layouts
// RQ15 - raw upper 8 bits, lsbs on gpio
// RQ16 - raw as two bytes, 8+2 format
// RQ17 - raw bypasses pipeline, qualifier timed
// RQ18 - bt.656 with embedded sync codes
// RQ19 - 640x480 progressive window of pipe output
// RQ20 - 8-bit port, 10 bits for raw
// RQ21 - fixed order pipeline, qualifiers travel along
`timescale 1ns/100ps
module color_pipe_out
  import color_pipe_pkg::*;
#(
  parameter int QUEUE_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire link_pins_t link_pins,
  input wire logic [89:0] auto_color_balance_coef,
  output logic [7:0] pixel_out_data,
  output logic [1:0] pixel_out_gpio,
  output logic pixel_out_clock,
  output logic out_frame_active,
  output logic out_row_active
);
  function automatic int clampi(int v, int hi);
    return (v < 0) ? 0 : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [11:0] ccm_dot(rgb12_t p, logic [29:0] k);
    int s;
    s = int'($signed(k[29:20])) * int'(p.r) + int'($signed(k[19:10])) * int'(p.g)
      + int'($signed(k[9:0])) * int'(p.b);
    return 12'(clampi(s >>> CCM_SHIFT, MAX12));
  endfunction

  function automatic logic [11:0] sharpen(logic [11:0] l, logic [11:0] c, logic [11:0] r,
                                          logic [3:0] gain, logic [7:0] thr);
    int d;
    d = 2 * int'(c) - int'(l) - int'(r);
    if (d > (int'(thr) << SHARP_THR_SHIFT) || -d > (int'(thr) << SHARP_THR_SHIFT)) begin
      return 12'(clampi(int'(c) + ((d * int'(gain)) >>> SHARP_SHIFT), MAX12));
    end
    return c;
  endfunction

  function automatic int knee_x(int k);
    return (k == 0) ? 0 : ((k == 1) ? KNEE_1 : ((k == 2) ? KNEE_2
      : (k - KNEE_COARSE_BASE) << KNEE_STEP_SHIFT));
  endfunction

  function automatic int gamma_map(logic [11:0] x, gamma_tbl_t t);
    int seg;
    int sh;
    int y0;
    int y1;
    if (int'(x) < KNEE_1) begin
      seg = 0;
      sh = KNEE_FINE_SHIFT;
    end else if (int'(x) < KNEE_2) begin
      seg = 1;
      sh = KNEE_FINE_SHIFT;
    end else if (int'(x) < (1 << KNEE_STEP_SHIFT)) begin
      seg = 2;
      sh = KNEE_MID_SHIFT;
    end else begin
      seg = (int'(x) >> KNEE_STEP_SHIFT) + KNEE_COARSE_BASE;
      sh = KNEE_STEP_SHIFT;
    end
    y0 = int'(t[seg]);
    y1 = int'(t[seg + 1]);
    return clampi(y0 + (((y1 - y0) * (int'(x) - knee_x(seg))) >>> sh), MAX8);
  endfunction

  function automatic logic [7:0] gamma_blend(logic [11:0] x, gamma_tbl_t tb, gamma_tbl_t td,
                                             logic [7:0] k);
    return 8'((gamma_map(x, tb) * (BLEND_ONE - int'(k)) + gamma_map(x, td) * int'(k)) >> FRAC8);
  endfunction

  function automatic logic [7:0] mat3(int a, int b, int c, int x, int y, int z, int off);
    return 8'(clampi(((a * x + b * y + c * z) >>> FRAC8) + off, MAX8));
  endfunction

  function automatic logic [7:0] lpf(logic [7:0] a, logic [7:0] b, logic [7:0] c,
                                     logic [7:0] d, logic [7:0] e, logic en, logic five);
    if (!en) return c;
    if (five) return 8'((int'(a) + 4 * int'(b) + 6 * int'(c) + 4 * int'(d) + int'(e)) >> 4);
    return 8'((int'(b) + 2 * int'(c) + int'(d)) >> 2);
  endfunction

  function automatic logic [9:0] word_index(logic [11:0] addr, logic [11:0] base);
    return 10'((addr - base) >> 2);
  endfunction

  // registers
  logic [CTRL_W-1:0] ctrl;
  logic [15:0] sharp;
  logic [7:0] blend;
  logic [15:0] kill;
  logic [CCM_N-1:0][CCM_W-1:0] ccm;
  gamma_tbl_t gam_bright;
  gamma_tbl_t gam_dark;
  logic [31:0] status;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic [31:0] rd_value;

  wire [11:0] ra_addr = haddr[11:0];
  wire ahb_take = hsel & htrans[1] & hready;
  wire [9:0] rd_ccm_i = word_index(ra_addr, REG_CCM_BASE);
  wire [9:0] rd_gb_i = word_index(ra_addr, REG_GAM_BRIGHT);
  wire [9:0] rd_gd_i = word_index(ra_addr, REG_GAM_DARK);
  wire [9:0] wr_ccm_i = word_index(wr_addr, REG_CCM_BASE);
  wire [9:0] wr_gb_i = word_index(wr_addr, REG_GAM_BRIGHT);
  wire [9:0] wr_gd_i = word_index(wr_addr, REG_GAM_DARK);
  wire rd_ccm_hit = ra_addr >= REG_CCM_BASE && int'(rd_ccm_i) < CCM_N;
  wire rd_gb_hit = ra_addr >= REG_GAM_BRIGHT && int'(rd_gb_i) < GAMMA_KNEES;
  wire rd_gd_hit = ra_addr >= REG_GAM_DARK && int'(rd_gd_i) < GAMMA_KNEES;
  wire wr_ccm_hit = wr_addr >= REG_CCM_BASE && int'(wr_ccm_i) < CCM_N;
  wire wr_gb_hit = wr_addr >= REG_GAM_BRIGHT && int'(wr_gb_i) < GAMMA_KNEES;
  wire wr_gd_hit = wr_addr >= REG_GAM_DARK && int'(wr_gd_i) < GAMMA_KNEES;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    rd_value = 32'h0000_0000;
    if (ra_addr[1:0] == 2'b00) begin
      if (ra_addr == REG_CTRL) rd_value = 32'(ctrl);
      else if (ra_addr == REG_SHARP) rd_value = 32'(sharp);
      else if (ra_addr == REG_BLEND) rd_value = 32'(blend);
      else if (ra_addr == REG_KILL) rd_value = 32'(kill);
      else if (ra_addr == REG_STATUS) rd_value = status;
      else if (rd_gd_hit) rd_value = 32'(gam_dark[rd_gd_i]);
      else if (rd_gb_hit) rd_value = 32'(gam_bright[rd_gb_i]);
      else if (rd_ccm_hit) rd_value = 32'(ccm[rd_ccm_i]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= ahb_take & hwrite;
      wr_addr <= ra_addr;
      hrdata <= (ahb_take & ~hwrite) ? rd_value : 32'h0000_0000;
    end
  end

  // gamma tables start from their defaults and stay loadable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
      sharp <= SHARP_RESET;
      blend <= BLEND_RESET;
      kill <= KILL_RESET;
      for (int i = 0; i < CCM_N; i++) ccm[i] <= (i % 4 == 0) ? CCM_UNITY : '0;
      gam_bright <= GAMMA_BRIGHT_RESET; // RQ4
      gam_dark <= GAMMA_DARK_RESET; // RQ4
    end else if (wr_pend && wr_addr[1:0] == 2'b00) begin
      if (wr_addr == REG_CTRL) ctrl <= hwdata[CTRL_W-1:0];
      if (wr_addr == REG_SHARP) sharp <= hwdata[15:0];
      if (wr_addr == REG_BLEND) blend <= hwdata[7:0];
      if (wr_addr == REG_KILL) kill <= hwdata[15:0];
      if (wr_ccm_hit && !wr_gb_hit) ccm[wr_ccm_i] <= hwdata[CCM_W-1:0]; // RQ2
      if (wr_gb_hit && !wr_gd_hit) gam_bright[wr_gb_i] <= hwdata[7:0]; // RQ6
      if (wr_gd_hit) gam_dark[wr_gd_i] <= hwdata[7:0]; // RQ6
    end
  end

  // link pins: two-stage synchroniser, edge found on the second stage
  link_pins_t sync1;
  link_pins_t sync2;
  logic link_clk_prev;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
      link_clk_prev <= 1'b0;
    end else begin
      sync1 <= link_pins;
      sync2 <= sync1;
      link_clk_prev <= sync2.clk;
    end
  end
  wire adv = sync2.clk & ~link_clk_prev;

  // processing pipeline, one stage per link pixel
  wire [89:0] coef = ctrl[CTRL_CCM_AUTO] ? auto_color_balance_coef : ccm; // RQ2
  wire rgb12_t in_rgb = '{r: {sync2.rgb[29:20], 2'b00}, g: {sync2.rgb[19:10], 2'b00},
                          b: {sync2.rgb[9:0], 2'b00}};
  wire rgb12_t ccm_out = '{r: ccm_dot(in_rgb, coef[89:60]), g: ccm_dot(in_rgb, coef[59:30]),
                           b: ccm_dot(in_rgb, coef[29:0])}; // RQ1
  rgb12_t s1, sh_c, sh_l, s2;
  yuv_t s4, s5, s6;
  logic [2:0][7:0] s3;
  logic [4:0] [23:0] lw;
  qual_t q1, qc, q2, q3, q4, q5;
  qual_t [4:0] lq;
  qual_t q6;
  wire [3:0] sh_gain = sharp[3:0];
  wire [7:0] sh_thr = sharp[15:8];
  wire rgb12_t shp = '{r: sharpen(sh_l.r, sh_c.r, s1.r, sh_gain, sh_thr),
                       g: sharpen(sh_l.g, sh_c.g, s1.g, sh_gain, sh_thr),
                       b: sharpen(sh_l.b, sh_c.b, s1.b, sh_gain, sh_thr)}; // RQ3
  wire [7:0] gr = gamma_blend(s2.r, gam_bright, gam_dark, blend); // RQ5
  wire [7:0] gg = gamma_blend(s2.g, gam_bright, gam_dark, blend); // RQ5
  wire [7:0] gb = gamma_blend(s2.b, gam_bright, gam_dark, blend); // RQ5
  wire yuv_t yuv = '{y: mat3(KY_R, KY_G, KY_B, int'(s3[2]), int'(s3[1]), int'(s3[0]), 0),
    u: mat3(KU_R, KU_G, KU_B, int'(s3[2]), int'(s3[1]), int'(s3[0]), CHROMA_MID),
    v: mat3(KV_R, KV_G, KV_B, int'(s3[2]), int'(s3[1]), int'(s3[0]), CHROMA_MID)}; // RQ7
  wire [7:0] kill_thr = kill[7:0];
  wire [7:0] kill_slope = kill[15:8];
  wire [7:0] kill_gain = 8'(clampi(BLEND_ONE - 1 - (int'(s4.y) - int'(kill_thr))
                          * int'(kill_slope), MAX8));
  wire kill_on = s4.y > kill_thr;
  wire yuv_t killed = '{y: s4.y,
    u: 8'(CHROMA_MID + (((int'(s4.u) - CHROMA_MID) * int'(kill_gain)) >>> FRAC8)),
    v: 8'(CHROMA_MID + (((int'(s4.v) - CHROMA_MID) * int'(kill_gain)) >>> FRAC8))}; // RQ8
  wire yuv_t lpf_out = '{
    y: lpf(lw[4][23:16], lw[3][23:16], lw[2][23:16], lw[1][23:16], lw[0][23:16],
           ctrl[CTRL_Y_LPF_EN], ctrl[CTRL_Y_LPF5]),
    u: lpf(lw[4][15:8], lw[3][15:8], lw[2][15:8], lw[1][15:8], lw[0][15:8],
           ctrl[CTRL_UV_LPF_EN], ctrl[CTRL_UV_LPF5]),
    v: lpf(lw[4][7:0], lw[3][7:0], lw[2][7:0], lw[1][7:0], lw[0][7:0],
           ctrl[CTRL_UV_LPF_EN], ctrl[CTRL_UV_LPF5])}; // RQ9

  // qualifiers ride in step with their pixel through every stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {s1, sh_c, sh_l, s2, s3, s4, s5, s6, lw} <= '0;
      {q1, qc, q2, q3, q4, q5, lq, q6} <= '0;
    end else if (adv) begin
      {s1, q1} <= {ccm_out, sync2.q}; // RQ21
      {sh_c, qc, sh_l} <= {s1, q1, sh_c};
      {s2, q2} <= {shp, qc};
      {s3, q3} <= {{gr, gg, gb}, q2};
      {s4, q4} <= {yuv, q3};
      {s5, q5} <= {kill_on ? killed : s4, q4}; // RQ8
      lw <= {lw[3:0], s5};
      lq <= {lq[3:0], q5};
      {s6, q6} <= {lpf_out, lq[2]}; // RQ21
    end
  end

  // preview window counters on the pipeline output
  logic [9:0] col_cnt;
  logic [8:0] row_cnt;
  logic prev_ra;
  logic ycc_odd;
  logic [7:0] u_hold, v_hold;
  wire out_fmt_t fmt = out_fmt_t'(ctrl[CTRL_FMT_LSB +: 3]);
  wire raw_mode = fmt == FMT_RAW_GPIO || fmt == FMT_RAW_2BYTE;
  wire in_window = int'(col_cnt) < PREVIEW_COLS && int'(row_cnt) < PREVIEW_ROWS;
  wire crop_ok = !ctrl[CTRL_CROP] || in_window; // RQ19
  wire qual_t src_q = raw_mode ? sync2.q : q6; // RQ17
  wire eff_ra = src_q.row_active & (raw_mode | crop_ok);
  wire swap_cbcr = ctrl[CTRL_SWAP_CBCR];
  wire swap_yc = ctrl[CTRL_SWAP_YC];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      col_cnt <= '0;
      row_cnt <= '0;
      prev_ra <= 1'b0;
      ycc_odd <= 1'b0;
      u_hold <= 8'h00;
      v_hold <= 8'h00;
    end else if (adv) begin
      col_cnt <= q6.row_active ? col_cnt + 10'(!(&col_cnt)) : '0; // RQ19
      if (!q6.frame_active) row_cnt <= '0;
      else if (col_cnt != '0 && !q6.row_active && !(&row_cnt)) row_cnt <= row_cnt + 9'd1;
      prev_ra <= eff_ra;
      ycc_odd <= eff_ra & ~ycc_odd; // RQ11
      if (eff_ra && !ycc_odd) {u_hold, v_hold} <= {s6.u, s6.v};
    end
  end

  // byte pair for the current pixel
  wire [7:0] chroma = ycc_odd ? (swap_cbcr ? u_hold : v_hold) : (swap_cbcr ? s6.v : s6.u);
  wire [7:0] cr = mat3(BLEND_ONE, 0, KR_V, int'(s6.y), 0, int'(s6.v) - CHROMA_MID, 0);
  wire [7:0] cg = mat3(BLEND_ONE, KG_U, KG_V, int'(s6.y), int'(s6.u) - CHROMA_MID,
                       int'(s6.v) - CHROMA_MID, 0);
  wire [7:0] cb = mat3(BLEND_ONE, KB_U, 0, int'(s6.y), int'(s6.u) - CHROMA_MID, 0, 0); // RQ10
  wire [7:0] rr = swap_cbcr ? cb : cr; // RQ12
  wire [7:0] bb = swap_cbcr ? cr : cb; // RQ12
  logic [7:0] rgb_odd, rgb_even, pb0, pb1;
  always_comb begin
    unique case (fmt)
      FMT_RGB565: {rgb_odd, rgb_even} = {rr[7:3], cg[7:2], bb[7:3]}; // RQ13
      FMT_RGB555: {rgb_odd, rgb_even} = {1'b0, rr[7:3], cg[7:3], bb[7:3]}; // RQ13
      FMT_RGB444X: {rgb_odd, rgb_even} = {rr[7:4], cg[7:4], bb[7:4], 4'h0}; // RQ14
      FMT_RGBX444: {rgb_odd, rgb_even} = {4'h0, rr[7:4], cg[7:4], bb[7:4]}; // RQ14
      default: {rgb_odd, rgb_even} = 16'h0000;
    endcase
    if (raw_mode) begin
      {pb0, pb1} = {sync2.raw[9:2], 6'h00, sync2.raw[1:0]}; // RQ16
    end else if (fmt == FMT_YCBCR || fmt == FMT_BT656) begin
      {pb0, pb1} = swap_yc ? {s6.y, chroma} : {chroma, s6.y}; // RQ11
    end else begin
      {pb0, pb1} = swap_yc ? {rgb_even, rgb_odd} : {rgb_odd, rgb_even}; // RQ12
    end
  end

  // bytes produced by this link pixel: optional sync code, then pixel bytes
  wire code_h = prev_ra & ~eff_ra;
  wire code_v = ~src_q.frame_active;
  wire [7:0] code_xy = {1'b1, 1'b0, code_v, code_h, code_v ^ code_h, code_h, code_v,
                        code_v ^ code_h};
  wire send_code = fmt == FMT_BT656 && (eff_ra != prev_ra); // RQ18
  wire [2:0] n_pix = !eff_ra ? 3'd0 : (fmt == FMT_RAW_GPIO ? 3'd1 : 3'd2); // RQ15
  wire [2:0] n_code = send_code ? 3'(CODE_LEN) : 3'd0;
  wire qual_t byte_q = '{frame_active: src_q.frame_active, row_active: 1'b1};
  wire qual_t code_q = '{frame_active: src_q.frame_active, row_active: 1'b0};
  out_byte_t [5:0] new_e;
  wire [1:0] gpio_lsb = fmt == FMT_RAW_GPIO ? sync2.raw[1:0] : 2'b00; // RQ15
  assign new_e[0] = send_code ? '{SYNC_FF, 2'b00, code_q}
                              : '{pb0, gpio_lsb, byte_q}; // RQ15
  assign new_e[1] = send_code ? '{SYNC_00, 2'b00, code_q} : '{pb1, 2'b00, byte_q};
  assign new_e[2] = '{SYNC_00, 2'b00, code_q};
  assign new_e[3] = '{code_xy, 2'b00, code_q}; // RQ18
  assign new_e[4] = '{pb0, 2'b00, byte_q};
  assign new_e[5] = '{pb1, 2'b00, byte_q};

  // byte queue and output strobe, two core cycles per byte
  out_byte_t [QUEUE_DEPTH-1:0] queue, next_queue;
  logic [3:0] count, next_count;
  logic phase;
  wire pop = phase && count != 4'd0;
  wire [2:0] n_new = adv ? n_code + n_pix : 3'd0;
  always_comb begin
    next_queue = queue;
    next_count = count;
    if (pop) begin
      for (int i = 0; i < QUEUE_DEPTH - 1; i++) next_queue[i] = queue[i + 1];
      next_count = count - 4'd1;
    end
    for (int k = 0; k < 6; k++) begin
      if (3'(k) < n_new && int'(next_count) < QUEUE_DEPTH) begin
        next_queue[next_count] = (n_code == 3'd0 && k < 2) ? new_e[k] : new_e[k];
        next_count = next_count + 4'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      queue <= '0;
      count <= 4'd0;
      phase <= 1'b0;
      pixel_out_data <= 8'h00;
      pixel_out_gpio <= 2'b00;
      pixel_out_clock <= 1'b0;
      out_frame_active <= 1'b0;
      out_row_active <= 1'b0;
    end else begin
      queue <= next_queue;
      count <= next_count;
      phase <= (count != 4'd0) & ~phase;
      pixel_out_clock <= pop; // RQ20
      if (count != 4'd0 && !phase) begin
        pixel_out_data <= queue[0].data;
        pixel_out_gpio <= queue[0].lsb; // RQ15
        out_frame_active <= queue[0].q.frame_active;
        out_row_active <= queue[0].q.row_active; // RQ17
      end else if (count == 4'd0) begin
        out_row_active <= 1'b0;
        out_frame_active <= src_q.frame_active;
      end
    end
  end

  assign status = {16'h0000, 7'h00, row_cnt[8:0] == 9'd0, count, 2'b00,
                   out_row_active, out_frame_active};
endmodule

// File: tb/color_pipe_out_monitor.sv
/*
  Checker for the colour pipe output block, core clock domain.
  Assumes it is bound to color_pipe_out and sees only its ports.
*/
`timescale 1ns/100ps
module color_pipe_out_monitor
  import color_pipe_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] pixel_out_data,
  input wire logic [1:0] pixel_out_gpio,
  input wire logic pixel_out_clock,
  input wire logic out_frame_active,
  input wire logic out_row_active
);
  logic rd_phase;
  logic wr_ctrl;
  logic [2:0] fmt;
  wire logic take = hsel && htrans[1] && hready;
  wire logic raw_mode = (fmt[2:1] == 2'b11);
  // output format as last written, tracked from the bus
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_phase <= 1'b0;
      wr_ctrl <= 1'b0;
      fmt <= 3'h0;
    end else begin
      rd_phase <= take && !hwrite;
      wr_ctrl <= take && hwrite && (haddr[11:0] == REG_CTRL);
      if (wr_ctrl)
        fmt <= hwdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  no_wait_a: assert property (hreadyout) else $error("wait state inserted");
  okay_resp_a: assert property (!hresp) else $error("error response");
  read_idle_a: assert property (!rd_phase |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  pulse_one_a: assert property ($rose(pixel_out_clock) |=> !pixel_out_clock)
    else $error("output clock high too long");
  byte_held_a: assert property ($rose(pixel_out_clock) |-> $stable(pixel_out_data))
    else $error("byte changed at clock rise");
  gpio_zero_a: assert property ($rose(pixel_out_clock) && fmt != 3'h6 |->
    pixel_out_gpio == 2'b00) else $error("low bits outside gpio mode");
  raw_row_a: assert property ($rose(pixel_out_clock) && raw_mode |-> out_row_active)
    else $error("raw byte without row qualifier");
  row_frame_a: assert property (out_row_active |-> out_frame_active)
    else $error("row active outside frame");
  cover property (rd_phase);
  cover property ($rose(pixel_out_clock) && fmt == 3'h6);
  cover property ($rose(pixel_out_clock) && fmt == 3'h7);
endmodule

bind color_pipe_out color_pipe_out_monitor color_pipe_out_monitor_i (.clk, .reset_n, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pixel_out_data,
  .pixel_out_gpio, .pixel_out_clock, .out_frame_active, .out_row_active);

// File: tb/byte_receiver.sv
/*
  Downstream receiver model: records every output byte.
  Assumes bytes are qualified by the rising output clock.
*/
`timescale 1ns/100ps
module byte_receiver (
  input wire logic pixel_out_clock,
  input wire logic [7:0] pixel_out_data,
  input wire logic [1:0] pixel_out_gpio,
  input wire logic out_row_active
);
  logic [10:0] got [$];
  always @(posedge pixel_out_clock) begin
    got.push_back({out_row_active, pixel_out_gpio, pixel_out_data});
  end
endmodule

// File: tb/test_color_pipe_out.sv
/*
  Bench for color_pipe_out: register defaults, processed rgb and raw bypass modes.
  Assumes the receiver model and the bound checker.
*/
`timescale 1ns/100ps
module test_color_pipe_out;
  import color_pipe_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, pixel_out_clock, out_frame_active, out_row_active;
  link_pins_t link_pins = '0;
  logic [7:0] pixel_out_data;
  logic [1:0] pixel_out_gpio;
  logic [9:0] pix_set [3] = '{10'h3ff, 10'h001, 10'h2a6};
  int bad_count = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  color_pipe_out color_pipe_out_i (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .link_pins,
    .auto_color_balance_coef(90'h0), .pixel_out_data, .pixel_out_gpio, .pixel_out_clock,
    .out_frame_active, .out_row_active);
  byte_receiver byte_receiver_i (.pixel_out_clock, .pixel_out_data, .pixel_out_gpio,
    .out_row_active);
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  // link clock runs only inside the frame, released pins show inverted data
  task automatic send_frame(input int n);
    byte_receiver_i.got.delete();
    link_pins.q <= 2'b11;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      link_pins.clk <= 1'b0;
      link_pins.raw <= pix_set[i % 3];
      repeat (4) @(posedge clk);
      link_pins.clk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    link_pins.clk <= 1'b0;
    link_pins.q <= 2'b00;
    link_pins.raw <= ~link_pins.raw;
    link_pins.rgb <= ~link_pins.rgb;
    repeat (16) @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk("ctrl", REG_CTRL, 32'h0);
    rd_chk("sharp", REG_SHARP, 32'h1002);
    rd_chk("kill", REG_KILL, 32'h00ff);
    rd_chk("ccm", REG_CCM_BASE, 32'h100);
    rd_chk("bright", REG_GAM_BRIGHT + 12'h4, 32'h04);
    rd_chk("dark", REG_GAM_DARK + 12'h4, 32'h28);
    bus(1'b1, REG_GAM_BRIGHT + 12'h14, 32'h5a);
    rd_chk("knee", REG_GAM_BRIGHT + 12'h14, 32'h5a);
    rd_chk("unmapped", 12'hffc, 32'h0);
    rd_chk("status", REG_STATUS, 32'h100);
    $display("test registers done");
    // white pixels: top gamma knee gives 254 on every channel, ten pixels stay in the pipe
    link_pins.rgb <= {3{10'h3ff}};
    bus(1'b1, REG_CTRL, 32'h25);
    send_frame(13);
    chk("rgb count", 32'h6, 32'(byte_receiver_i.got.size()));
    for (int i = 0; i < 6; i++) begin
      chk("x444 byte", i % 2 ? 32'h40f : 32'h4ff, 32'(byte_receiver_i.got[i]));
    end
    $display("test rgb x444 done");
    bus(1'b1, REG_CTRL, 32'h6);
    send_frame(3);
    chk("gpio count", 32'h3, 32'(byte_receiver_i.got.size()));
    foreach (pix_set[i]) begin
      chk("gpio byte", {21'h1, pix_set[i][1:0], pix_set[i][9:2]}, 32'(byte_receiver_i.got[i]));
    end
    $display("test raw gpio done");
    bus(1'b1, REG_CTRL, 32'h7);
    send_frame(3);
    chk("pair count", 32'h6, 32'(byte_receiver_i.got.size()));
    foreach (pix_set[i]) begin
      chk("odd byte", {24'h4, pix_set[i][9:2]}, 32'(byte_receiver_i.got[2*i]));
      chk("even byte", {30'h100, pix_set[i][1:0]}, 32'(byte_receiver_i.got[2*i+1]));
    end
    $display("test raw two byte done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule
